// ### core/ptb_pkg.sv
// Constants and types shared by the PWM time-base block
package ptb_pkg;
   // ----------------------------------------
   // Key and access codes
   // ----------------------------------------
   localparam logic [15:0] KEY_FIRST = 16'hABCD;
   localparam logic [15:0] KEY_SECOND = 16'h4321;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int LOCK_CFG_BIT = 6;
   localparam int GEN_CAM_BIT = 2;
   localparam int GEN_ITB_BIT = 3;
   localparam int TB_SRC_LO = 4;
   localparam int TB_SYNC_INPUT_ENABLE_BIT = 7;
   localparam int TB_SYNC_OUTPUT_ENABLE_BIT = 8;
   localparam int TB_SYNC_POLARITY_BIT = 9;
   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] PERIOD_RST = 16'hFFFF;
   localparam int SYNC_OUT_TCY = 12;
   localparam logic [2:0] DIV_RST = 3'h0;
   // Access codes driven by the register port
   typedef enum logic [2:0] {
      PTB_ACC_NONE,
      PTB_ACC_KEY,
      PTB_ACC_OUTCTL,
      PTB_ACC_FLTCTL,
      PTB_ACC_OTHER
   } ptb_acc_t;
   // Unlock sequence states
   typedef enum logic [1:0] {
      PTB_LK_IDLE,
      PTB_LK_KEY1,
      PTB_LK_OPEN
   } ptb_lock_t;
endpackage

// ### core/ptb_prescaler.sv
// Clock prescaler producing a one-cycle enable pulse
`timescale 1ns/1ps
module ptb_prescaler (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic [2:0] i_div_sel,
   output logic o_tick
);
   logic [5:0] cnt_reg;
   logic [5:0] limit;

   // Divide by 2**sel for sel 0 to 6: wrap limit is 2**sel - 1; sel 7 also wraps at 63, so from 1:1 up to 1:64
   assign limit = 6'(7'h7F >> (3'h7 - i_div_sel));

   // ----------------------------------------
   // Divider counter
   // ----------------------------------------
   // Count to limit, pulse on wrap
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_reg <= 6'h00;
         o_tick <= 1'b0;
      end else if (cnt_reg >= limit) begin
         cnt_reg <= 6'h00;
         o_tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 6'h01;
         o_tick <= 1'b0;
      end
   end
endmodule

// ### core/ptb_time_base.sv
// PWM time base with write lock, generator counter and master sync
`timescale 1ns/1ps
// Summary of operation
// RQ1: Lock output and fault control when bit set
// RQ2: Key writes ABCD then 4321 unlock
// RQ3: Protected write must be next access
// RQ4: One unlock grants exactly one write
// RQ5: Any other access abandons the unlock
// RQ6: Edge-aligned counter counts up from zero
// RQ7: Output high while counter not above duty
// RQ8: Counter clears at or beyond period
// RQ9: Bit 2 selects centre-aligned mode
// RQ10: Centre mode counts up then down
// RQ11: Centre bit ignored unless independent base
// RQ12: Sixteen-bit master period, system-clocked timer
// RQ13: Phase registers offset outputs from master
// RQ14: Bits 5:4 choose sync input source
// RQ15: Bit 9 picks sync edge polarity
// RQ16: Bit 7 enables external sync reset
// RQ17: Sync pulses wide, continuous, 200 ns
// RQ18: Period match emits twelve-cycle sync pulse
// RQ19: Bit 8 enables sync out, polarity follows
// RQ20: Sync reset lags edge about 2.5 ticks
// RQ21: Push-pull sync period multiple of eight
// RQ22: No external sync with independent base
// RQ23: First two sync pulses may distort output
// RQ24: Prescaler 1:1 to 1:64, three-bit field
module ptb_time_base (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_write_lock_config_bit,
   input wire logic [2:0] i_acc_kind,
   input wire logic i_acc_valid,
   input wire logic [15:0] i_acc_wdata,
   input wire logic [15:0] i_generator_control,
   input wire logic [15:0] i_time_base_control,
   input wire logic [2:0] i_input_clock_divider,
   input wire logic [15:0] i_master_period,
   input wire logic [15:0] i_primary_phase,
   input wire logic [15:0] i_secondary_phase,
   input wire logic [15:0] i_duty,
   input wire logic [3:0] i_sync_input,
   output logic [15:0] o_output_control,
   output logic [15:0] o_fault_limit_control,
   output logic o_unlocked,
   output logic o_pwm_h,
   output logic o_pwm_l,
   output logic o_sync_output,
   output logic o_sync_output_en,
   output logic [15:0] o_master_timer
);
   ptb_pkg::ptb_lock_t lk_reg;
   logic tick;
   logic [15:0] gen_cnt_reg;
   logic dir_down_reg;
   logic [15:0] sec_cnt_reg;
   logic [3:0] sync_s1_reg;
   logic [3:0] sync_s2_reg;
   logic sync_prev_reg;
   logic [1:0] sync_dly_reg;
   logic [3:0] so_cnt_reg;
   logic sync_sel;
   logic sync_edge;
   logic sync_rst;
   logic mt_match;
   logic cam_on;
   logic itb_on;
   logic pol;
   logic key_acc;
   logic prot_acc;
   logic [15:0] gen_period;

   // ----------------------------------------
   // Prescaler
   // ----------------------------------------
   ptb_prescaler u_presc (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_div_sel(i_input_clock_divider), // RQ24
      .o_tick(tick)
   );

   // ----------------------------------------
   // Write protection
   // ----------------------------------------
   assign key_acc = i_acc_valid && (i_acc_kind == 3'(ptb_pkg::PTB_ACC_KEY));
   assign prot_acc = i_acc_valid && ((i_acc_kind == 3'(ptb_pkg::PTB_ACC_OUTCTL))
      || (i_acc_kind == 3'(ptb_pkg::PTB_ACC_FLTCTL)));
   assign o_unlocked = !i_write_lock_config_bit || (lk_reg == ptb_pkg::PTB_LK_OPEN);

   // Unlock sequencer, reset by any unexpected access
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         lk_reg <= ptb_pkg::PTB_LK_IDLE;
      end else if (i_acc_valid) begin
         case (lk_reg)
            ptb_pkg::PTB_LK_IDLE: begin
               if (key_acc && i_acc_wdata == ptb_pkg::KEY_FIRST) begin // RQ2
                  lk_reg <= ptb_pkg::PTB_LK_KEY1;
               end
            end
            ptb_pkg::PTB_LK_KEY1: begin
               if (key_acc && i_acc_wdata == ptb_pkg::KEY_SECOND) begin // RQ2
                  lk_reg <= ptb_pkg::PTB_LK_OPEN;
               end else if (key_acc && i_acc_wdata == ptb_pkg::KEY_FIRST) begin
                  lk_reg <= ptb_pkg::PTB_LK_KEY1;
               end else begin
                  lk_reg <= ptb_pkg::PTB_LK_IDLE; // RQ5
               end
            end
            ptb_pkg::PTB_LK_OPEN: begin
               lk_reg <= ptb_pkg::PTB_LK_IDLE; // RQ3 RQ4 RQ5
            end
            default: begin
               lk_reg <= ptb_pkg::PTB_LK_IDLE;
            end
         endcase
      end
   end

   // Protected registers take a write only while unlocked
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_output_control <= ptb_pkg::CTRL_RST;
         o_fault_limit_control <= ptb_pkg::CTRL_RST;
      end else if (prot_acc && o_unlocked) begin // RQ1
         if (i_acc_kind == 3'(ptb_pkg::PTB_ACC_OUTCTL)) begin
            o_output_control <= i_acc_wdata;
         end else begin
            o_fault_limit_control <= i_acc_wdata;
         end
      end
   end

   // ----------------------------------------
   // Sync input capture
   // ----------------------------------------
   assign pol = i_time_base_control[ptb_pkg::TB_SYNC_POLARITY_BIT];

   // Two-stage synchroniser on the pins
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         sync_s1_reg <= 4'h0;
         sync_s2_reg <= 4'h0;
      end else begin
         sync_s1_reg <= i_sync_input;
         sync_s2_reg <= sync_s1_reg;
      end
   end

   assign sync_sel = sync_s2_reg[i_time_base_control[ptb_pkg::TB_SRC_LO +: 2]]; // RQ14

   // Edge sampled on the prescaled tick, then delayed two more ticks
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         sync_prev_reg <= 1'b0;
         sync_dly_reg <= 2'h0;
      end else if (tick) begin
         sync_prev_reg <= sync_sel;
         sync_dly_reg <= {sync_dly_reg[0], sync_edge}; // RQ20
      end
   end

   assign sync_edge = pol ? (sync_prev_reg && !sync_sel) : (!sync_prev_reg && sync_sel); // RQ15
   assign sync_rst = tick && sync_dly_reg[1]
      && i_time_base_control[ptb_pkg::TB_SYNC_INPUT_ENABLE_BIT]; // RQ16

   // ----------------------------------------
   // Master timer
   // ----------------------------------------
   assign mt_match = o_master_timer >= i_master_period;

   // Master count on the prescaled tick
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_master_timer <= 16'h0000;
      end else if (sync_rst) begin
         o_master_timer <= 16'h0000; // RQ16
      end else if (tick) begin
         o_master_timer <= mt_match ? 16'h0000 : o_master_timer + 16'h0001; // RQ12
      end
   end

   // Sync output pulse counter
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         so_cnt_reg <= 4'h0;
      end else if (tick && mt_match && !sync_rst) begin
         so_cnt_reg <= 4'(ptb_pkg::SYNC_OUT_TCY); // RQ18
      end else if (so_cnt_reg != 4'h0) begin
         so_cnt_reg <= so_cnt_reg - 4'h1;
      end
   end

   assign o_sync_output_en = i_time_base_control[ptb_pkg::TB_SYNC_OUTPUT_ENABLE_BIT]; // RQ19
   assign o_sync_output = o_sync_output_en && ((so_cnt_reg != 4'h0) ^ pol); // RQ19

   // ----------------------------------------
   // Generator counters
   // ----------------------------------------
   assign itb_on = i_generator_control[ptb_pkg::GEN_ITB_BIT];
   assign cam_on = itb_on && i_generator_control[ptb_pkg::GEN_CAM_BIT]; // RQ11 RQ9
   assign gen_period = itb_on ? i_primary_phase : i_master_period;

   // Primary counter: phase offset on master, or own period
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         gen_cnt_reg <= 16'h0000;
         dir_down_reg <= 1'b0;
      end else if (!itb_on && (sync_rst || (tick && mt_match))) begin
         gen_cnt_reg <= i_primary_phase; // RQ13 RQ23
         dir_down_reg <= 1'b0;
      end else if (tick && cam_on) begin
         if (!dir_down_reg && gen_cnt_reg >= gen_period) begin
            dir_down_reg <= 1'b1; // RQ10
            gen_cnt_reg <= gen_cnt_reg - 16'h0001;
         end else if (dir_down_reg && gen_cnt_reg == 16'h0000) begin
            dir_down_reg <= 1'b0;
            gen_cnt_reg <= 16'h0001;
         end else begin
            gen_cnt_reg <= dir_down_reg ? gen_cnt_reg - 16'h0001 : gen_cnt_reg + 16'h0001;
         end
      end else if (tick) begin
         dir_down_reg <= 1'b0;
         gen_cnt_reg <= (gen_cnt_reg >= gen_period) ? 16'h0000 : // RQ8
            gen_cnt_reg + 16'h0001; // RQ6
      end
   end

   // Secondary counter: own period in independent mode, phase on master
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         sec_cnt_reg <= 16'h0000;
      end else if (!itb_on && (sync_rst || (tick && mt_match))) begin
         sec_cnt_reg <= i_secondary_phase; // RQ13
      end else if (tick) begin
         sec_cnt_reg <= (sec_cnt_reg >= (itb_on ? i_secondary_phase : i_master_period))
            ? 16'h0000 : sec_cnt_reg + 16'h0001; // RQ8
      end
   end

   // Duty comparators, registered outputs
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pwm_h <= 1'b0;
         o_pwm_l <= 1'b0;
      end else begin
         o_pwm_h <= gen_cnt_reg <= i_duty; // RQ7
         o_pwm_l <= sec_cnt_reg <= i_duty; // RQ7
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_key_pair;
      lk_reg != ptb_pkg::PTB_LK_OPEN && key_acc && i_acc_wdata == ptb_pkg::KEY_FIRST
      ##1 !i_acc_valid ##1 key_acc && i_acc_wdata == ptb_pkg::KEY_SECOND;
   endsequence

   a_lock_blocks_write: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RQ1
      i_write_lock_config_bit && lk_reg != ptb_pkg::PTB_LK_OPEN && prot_acc
      && i_acc_kind == 3'(ptb_pkg::PTB_ACC_OUTCTL)
      |=> $stable(o_output_control))
      else $error("locked output control changed");

   a_key_opens: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RQ2
      s_key_pair |=> lk_reg == ptb_pkg::PTB_LK_OPEN)
      else $error("key pair did not unlock");

   a_one_write_only: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RQ4
      lk_reg == ptb_pkg::PTB_LK_OPEN && i_acc_valid |=> lk_reg == ptb_pkg::PTB_LK_IDLE)
      else $error("unlock outlived one access");

   a_stray_abandons: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RQ5
      lk_reg == ptb_pkg::PTB_LK_KEY1 && i_acc_valid && !key_acc
      |=> lk_reg == ptb_pkg::PTB_LK_IDLE)
      else $error("stray access kept unlock");

   a_edge_wraps: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RQ8
      tick && !cam_on && itb_on && gen_cnt_reg >= gen_period |=> gen_cnt_reg == 16'h0000)
      else $error("counter did not wrap");

   a_duty_compare: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RQ7
      1'b1 |=> o_pwm_h == ($past(gen_cnt_reg) <= $past(i_duty)))
      else $error("output disagrees with duty");

   a_cam_ignored: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RQ11
      !itb_on && tick |=> !dir_down_reg)
      else $error("centre mode without independent base");

   a_sync_pulse_len: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RQ18
      $rose(so_cnt_reg != 4'h0) |-> (so_cnt_reg != 4'h0) [*8] ##4 (so_cnt_reg != 4'h0)
      ##1 (so_cnt_reg == 4'h0 || $past(so_cnt_reg) != 4'h1 || $past(tick && mt_match)))
      else $error("sync pulse length wrong");

   a_sync_out_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RQ19
      !o_sync_output_en |-> !o_sync_output)
      else $error("sync output driven while disabled");

   a_sync_disabled: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RQ16
      !i_time_base_control[ptb_pkg::TB_SYNC_INPUT_ENABLE_BIT] && tick && !mt_match
      |=> o_master_timer == $past(o_master_timer) + 16'h0001)
      else $error("sync reset while disabled");
endmodule

// ### tb/ptb_sync_src.sv
// Model of an external power controller sending time-base sync pulses
`timescale 1ns/1ps
module ptb_sync_src #(
   parameter int WIDTH = 4
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_fire,
   input wire logic [1:0] i_src,
   input wire logic i_pol,
   output logic [3:0] o_sync
);
   logic [3:0] cnt_reg;
   // ----------------------------------------
   // Pulse timer, four cycles is 400 ns
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_reg <= 4'h0;
      end else if (i_fire) begin
         cnt_reg <= 4'(WIDTH);
      end else if (cnt_reg != 4'h0) begin
         cnt_reg <= cnt_reg - 4'h1;
      end
   end
   // Idle lines rest at the inactive level
   assign o_sync = {4{i_pol}} ^ ((cnt_reg != 4'h0) ? (4'h1 << i_src) : 4'h0);
endmodule

// ### tb/tb_ptb_time_base.sv
// Self-checking bench for the PWM time-base block
`timescale 1ns/1ps
module tb_ptb_time_base;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic clk = 0, rstn = 0, lock = 1, valid = 0, fire = 0;
   logic [1:0] src = 2'h0;
   logic [2:0] kind = 3'h0, div = 3'h0;
   logic [15:0] wdata = 16'h0000, gen = 16'h0000, tbc = 16'h0000, per = 16'h0009;
   logic [15:0] ph1 = 16'h000A, duty = 16'h0003;
   logic [3:0] sync;
   logic [15:0] octl, fctl, tmr;
   logic unl, ph, pl, so, soe;
   int num_errors = 0, tests_run = 0;
   ptb_time_base ptb_time_base_i (.i_clk_sys(clk), .i_rstn(rstn),
      .i_write_lock_config_bit(lock), .i_acc_kind(kind), .i_acc_valid(valid),
      .i_acc_wdata(wdata), .i_generator_control(gen), .i_time_base_control(tbc),
      .i_input_clock_divider(div), .i_master_period(per), .i_primary_phase(ph1),
      .i_secondary_phase(ph1), .i_duty(duty), .i_sync_input(sync),
      .o_output_control(octl), .o_fault_limit_control(fctl), .o_unlocked(unl),
      .o_pwm_h(ph), .o_pwm_l(pl), .o_sync_output(so), .o_sync_output_en(soe),
      .o_master_timer(tmr));
   ptb_sync_src ptb_sync_src_i (.i_clk(clk), .i_rstn(rstn), .i_fire(fire),
      .i_src(src), .i_pol(tbc[9]), .o_sync(sync));
   initial begin
      forever #50 clk = ~clk;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks=%0d errors=%0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task automatic acc(input logic [2:0] k, input logic [15:0] d);
      cyc(1);
      valid = 1;
      kind = k;
      wdata = d;
      cyc(1);
      valid = 0;
   endtask
   task automatic pulse;
      fire = 1;
      cyc(1);
      fire = 0;
   endtask
   // One master period: length, output highs, sync highs, peak count
   task automatic meas(output int n, output int hi, output int sh, output logic [15:0] mx);
      logic [15:0] lst;
      n = 0;
      hi = 0;
      sh = 0;
      mx = 16'h0000;
      while (tmr === 16'h0000 && n < 999) cyc(1);
      while (tmr !== 16'h0000 && n < 99999) begin
         cyc(1);
         n++;
      end
      n = 0;
      do begin
         n++;
         hi += int'(ph);
         sh += int'(so);
         if (tmr > mx) mx = tmr;
         lst = tmr;
         cyc(1);
      end while (!(tmr === 16'h0000 && lst !== 16'h0000) && n < 9999);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_lock;
      lock = 0;
      acc(3'h2, 16'hBEEF);
      chk(octl, 16'hBEEF);
      lock = 1;
      acc(3'h2, 16'h1234);
      chk(octl, 16'hBEEF);
      acc(3'h1, 16'hABCD);
      acc(3'h1, 16'h4321);
      chk(unl, 1'b1);
      acc(3'h2, 16'h1234);
      chk(octl, 16'h1234);
      acc(3'h3, 16'h5555);
      chk(fctl, 16'h0000);
      acc(3'h1, 16'hABCD);
      acc(3'h1, 16'h4321);
      acc(3'h4, 16'h0000);
      acc(3'h3, 16'h5555);
      chk(fctl, 16'h0000);
      acc(3'h1, 16'hABCD);
      acc(3'h3, 16'h5555);
      chk(fctl, 16'h0000);
      acc(3'h1, 16'hABCD);
      acc(3'h1, 16'h4321);
      acc(3'h3, 16'h5555);
      chk(fctl, 16'h5555);
   endtask
   task automatic t_edge;
      int n, hi, sh;
      logic [15:0] mx;
      for (int g = 0; g < 2; g++) begin
         gen = g ? 16'h0004 : 16'h0000;
         meas(n, hi, sh, mx);
         meas(n, hi, sh, mx);
         chk(16'(n), 16'h000A);
         chk(16'(hi), 16'h0004);
         chk(mx, 16'h0009);
      end
      per = 16'h0007;
      for (int d = 0; d < 4; d++) begin
         div = 3'(d);
         meas(n, hi, sh, mx);
         meas(n, hi, sh, mx);
         chk(16'(n), 16'(8 << d));
      end
      div = 3'h0;
   endtask
   // Cycles between two rising edges of the high or the low output
   task automatic gap(input bit low, output int n);
      logic p, c;
      n = 0;
      p = 1'b1;
      c = low ? pl : ph;
      while (!(c === 1'b1 && p === 1'b0) && n < 999) begin
         p = c;
         cyc(1);
         c = low ? pl : ph;
         n++;
      end
      n = 0;
      do begin
         p = c;
         cyc(1);
         c = low ? pl : ph;
         n++;
      end while (!(c === 1'b1 && p === 1'b0) && n < 999);
   endtask
   task automatic t_centre;
      int n;
      gen = 16'h000C;
      cyc(50);
      gap(1'b0, n);
      chk(16'(n), 16'h0014);
      gap(1'b1, n);
      chk(16'(n), 16'h000B);
      gen = 16'h0008;
      cyc(50);
      gap(1'b0, n);
      chk(16'(n), 16'h000B);
      gen = 16'h0000;
   endtask
   task automatic t_sync_out;
      int n, hi, sh;
      logic [15:0] mx;
      per = 16'h001F;
      tbc = 16'h0100;
      meas(n, hi, sh, mx);
      meas(n, hi, sh, mx);
      chk(16'(sh), 16'h000C);
      chk(soe, 1'b1);
      chk(mx, 16'h001F);
      tbc = 16'h0300;
      meas(n, hi, sh, mx);
      meas(n, hi, sh, mx);
      chk(16'(sh), 16'h0014);
      tbc = 16'h0000;
      cyc(2);
      chk(soe, 1'b0);
   endtask
   // Other party keeps the period a multiple of eight, dependent base
   task automatic t_sync_in;
      per = 16'hFFF8;
      for (int s = 0; s < 4; s++) begin
         tbc = 16'h0000;
         cyc(5);
         tbc = 16'h0080 | (16'(s) << 4) | (16'(s & 1) << 9);
         src = 2'(s + 1);
         cyc(40);
         pulse;
         cyc(9);
         chk(tmr > 16'h0020, 16'h0001);
         src = 2'(s);
         pulse;
         cyc(9);
         chk(tmr < 16'h000A, 16'h0001);
         tbc[7] = 1'b0;
         cyc(40);
         pulse;
         cyc(9);
         chk(tmr > 16'h0020, 16'h0001);
      end
   endtask
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      cyc(12);
      rstn = 1;
      chk(octl, 16'h0000);
      chk(fctl, 16'h0000);
      t_lock;
      t_edge;
      t_centre;
      t_sync_out;
      t_sync_in;
      end_sim;
   end
   initial begin
      #5_000_000;
      num_errors++;
      end_sim;
   end
endmodule
